// File: include/cssd_pkg.sv
// Shared constants and types for the cyclic setpoint and step/direction front end.
package cssd_pkg;

   // Object indices of the register map.
   localparam logic [15:0] IDX_STEP_NUM     = 16'h2057;
   localparam logic [15:0] IDX_STEP_DEN     = 16'h2058;
   localparam logic [15:0] IDX_CONTROL      = 16'h6040;
   localparam logic [15:0] IDX_STATUS       = 16'h6041;
   localparam logic [15:0] IDX_MODE_SELECT  = 16'h6060;
   localparam logic [15:0] IDX_TQ_SETPOINT  = 16'h6071;
   localparam logic [15:0] IDX_TQ_CEILING   = 16'h6072;
   localparam logic [15:0] IDX_CUR_CEILING  = 16'h6073;
   localparam logic [15:0] IDX_TQ_READBACK  = 16'h6074;
   localparam logic [15:0] IDX_SPD_CEILING  = 16'h6080;
   localparam logic [15:0] IDX_VEL_OFFSET   = 16'h60B1;
   localparam logic [15:0] IDX_TQ_OFFSET    = 16'h60B2;
   localparam logic [15:0] IDX_VEL_SETPOINT = 16'h60FF;

   // Values after reset.
   localparam logic [31:0] RST_STEP_NUM = 32'h0000_0080;
   localparam logic [31:0] RST_STEP_DEN = 32'h0000_0001;
   localparam logic [31:0] RST_ZERO32   = 32'h0000_0000;
   localparam logic [15:0] RST_ZERO16   = 16'h0000;
   localparam logic [7:0]  RST_MODE     = 8'h00;

   // Operating-mode selector codes.
   localparam logic [7:0] MODE_CODE_CSV  = 8'h09;
   localparam logic [7:0] MODE_CODE_CST  = 8'h0A;
   localparam logic [7:0] MODE_CODE_STEP = 8'hFF;

   // Status word bit positions.
   localparam int SW_SYNC_BIT   = 8;
   localparam int SW_FOLLOW_BIT = 12;
   localparam int SW_FERR_BIT   = 13;

   // Timing: the cycle base is one millisecond.
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          TIME_BASE_NS  = 1000000;
   localparam int unsigned CYCLES_PER_MS = TIME_BASE_NS / CLK_PERIOD_NS;
   localparam logic [7:0]  TIME_INDEX_MS = 8'hFD;

   // Step geometry and pulse counting.
   localparam int          FULL_STEPS_PER_POLE_PAIR = 4;
   localparam logic        SUBTYPE_CLK_DIR          = 1'b0;
   localparam logic        SUBTYPE_CW_CCW           = 1'b1;
   localparam int          CNT_W                    = 16;
   localparam int          DVD_W                    = 48;
   localparam logic [5:0]  DIV_STEPS                = 6'h30;

   typedef enum logic [1:0] {MODE_OFF, MODE_CSV, MODE_CST, MODE_STEP} cssd_mode_e;
   typedef enum logic {DIV_IDLE, DIV_RUN} cssd_div_e;

endpackage : cssd_pkg

// File: logic/cssd_sync2.sv
// Two flip-flop synchroniser for levels or gray-coded words.
module cssd_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // The first stage feeds only the second.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : cssd_sync2

// File: logic/cssd_step_capture.sv
// Link-domain pulse capture: counts step pulses into a gray-coded running total.
module cssd_step_capture
   import cssd_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             step_i,
   input  wire logic             dir_i,
   input  wire logic             subtype_i,
   output logic      [CNT_W-1:0] total_gray_o
);
   logic [1:0]       rst_sync_q;
   logic             rst_n;
   logic [2:0]       pins;
   logic             step_prev_q;
   logic             dir_prev_q;
   logic             step_rise;
   logic             dir_rise;
   logic [CNT_W-1:0] total_q;
   logic [CNT_W-1:0] total_d;

   // Reset level brought over from the core domain.
   always_ff @(posedge clk_i) begin
      rst_sync_q <= {rst_sync_q[0], rst_n_i};
   end
   assign rst_n = rst_sync_q[1];

   // Pins pass two flops before any edge detection.
   cssd_sync2 #(.W(3)) u_pin_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .d_i     ({subtype_i, dir_i, step_i}),
      .q_o     (pins)
   );

   // Edge history of the synchronised pins.
   always_ff @(posedge clk_i) begin
      if (!rst_n) begin
         step_prev_q <= 1'b0;
         dir_prev_q  <= 1'b0;
      end else begin
         step_prev_q <= pins[0];
         dir_prev_q  <= pins[1];
      end
   end
   assign step_rise = pins[0] & ~step_prev_q;
   assign dir_rise  = pins[1] & ~dir_prev_q;

   // Signed running count: up for forward, down for reverse.
   always_comb begin
      total_d = total_q;
      if (pins[2] == SUBTYPE_CLK_DIR) begin
         if (step_rise) begin
            total_d = pins[1] ? total_q + 16'h0001 : total_q - 16'h0001;
         end
      end else begin
         if (step_rise && !dir_rise) begin
            total_d = total_q + 16'h0001;
         end else if (dir_rise && !step_rise) begin
            total_d = total_q - 16'h0001;
         end
      end
   end

   // Total and its gray code; only the gray code leaves this domain.
   always_ff @(posedge clk_i) begin
      if (!rst_n) begin
         total_q      <= '0;
         total_gray_o <= '0;
      end else begin
         total_q      <= total_d;
         total_gray_o <= total_d ^ (total_d >> 1);
      end
   end
endmodule : cssd_step_capture

// File: logic/cssd_top.sv
// Command front end: cyclic velocity/torque setpoints and step/direction positioning.
// How it works
// - Mode code 9 selects cyclic velocity.
// - Mode code 10 selects cyclic torque.
// - Mode code FFh selects step/direction.
// - Status bit 8 shows fieldbus sync in cyclic modes.
// - Status bit 12 shows setpoint followed.
// - Control word bits unused in cyclic modes.
// - Torque clamped to min of ceilings.
// - Cycle time is period times base.
// - Only time index -3 supported.
// - Torque offset added to torque setpoint.
// - Velocity offset added to velocity setpoint.
// - Torque mode needs closed loop.
// - One step per pulse, dir sets sense.
// - Pulses applied once per cycle.
// - Pulse scaled by numerator over denominator.
// - Status bit 13 flags following error.
// - Brushless: four full steps per pole pair.
// - Error only after outside window past timeout.
// - Subtype 0: clock pulses, direction input.
// - Subtype 1: input used gives sense.
module cssd_top
   import cssd_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = cssd_pkg::CYCLES_PER_MS
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        LINK_CLK_I,
   input  wire logic        STEP_CLK_I,
   input  wire logic        STEP_DIR_I,
   input  wire logic        STEP_SUBTYPE_I,
   input  wire logic        SYNC_I,
   input  wire logic        OP_ENABLED_I,
   input  wire logic        CLOSED_LOOP_I,
   input  wire logic [7:0]  CYCLE_PERIOD_I,
   input  wire logic [7:0]  TIME_INDEX_I,
   input  wire logic [31:0] ACTUAL_POS_I,
   input  wire logic [31:0] FE_WINDOW_I,
   input  wire logic [15:0] FE_TIMEOUT_I,
   input  wire logic [7:0]  POLE_PAIRS_I,
   input  wire logic        OBJ_WR_I,
   input  wire logic        OBJ_RD_I,
   input  wire logic [15:0] OBJ_INDEX_I,
   input  wire logic [31:0] OBJ_WDATA_I,
   output logic      [31:0] OBJ_RDATA_O,
   output logic             OBJ_ACK_O,
   output logic             OBJ_ERR_O,
   output logic      [31:0] VEL_DEMAND_O,
   output logic      [15:0] TORQUE_DEMAND_O,
   output logic      [31:0] POS_DEMAND_O,
   output logic      [15:0] STATUS_WORD_O,
   output logic             CYCLE_TICK_O,
   output logic             TIME_INDEX_ERR_O,
   output logic      [15:0] STEPS_PER_REV_O
);
   // Register file.
   logic [31:0]      num_q;
   logic [31:0]      den_q;
   logic [15:0]      ctrl_q;
   logic [7:0]       mode_q;
   logic [15:0]      tq_set_q;
   logic [15:0]      tq_max_q;
   logic [15:0]      cur_max_q;
   logic [31:0]      spd_max_q;
   logic [31:0]      vel_off_q;
   logic [15:0]      tq_off_q;
   logic [31:0]      vel_set_q;
   // Mode, timing and status.
   cssd_mode_e       mode;
   logic             follow;
   logic [31:0]      ms_cnt_q;
   logic             ms_tick;
   logic [7:0]       cyc_cnt_q;
   logic [7:0]       period_last;
   logic             index_ok;
   logic             cycle_tick;
   logic             sync_seen_q;
   logic             in_sync_q;
   logic             ferr_q;
   logic [15:0]      fe_ms_q;
   logic [15:0]      status;
   logic [31:0]      rd_mux;
   logic             rd_hit;
   logic             wr_ok;
   // Setpoint arithmetic.
   logic [32:0]      vel_sum;
   logic [32:0]      vel_lim;
   logic [16:0]      tq_sum;
   logic [16:0]      tq_lim;
   // Pulse transfer and scaling.
   logic [CNT_W-1:0] gray_sync_src;
   logic [CNT_W-1:0] gray_sync;
   logic [CNT_W-1:0] total_bin;
   logic [CNT_W-1:0] snap_q;
   logic [CNT_W-1:0] delta;
   logic [CNT_W-1:0] delta_mag;
   cssd_div_e        div_st_q;
   logic [5:0]       div_cnt_q;
   logic [DVD_W-1:0] dvd_q;
   logic [32:0]      rem_q;
   logic [32:0]      rem_sh;
   logic             neg_q;
   logic [31:0]      pos_err;
   logic [31:0]      pos_err_mag;

   // Mode decode from the selector code.
   always_comb begin
      unique case (mode_q)
         MODE_CODE_CSV:  mode = MODE_CSV;
         MODE_CODE_CST:  mode = MODE_CST;
         MODE_CODE_STEP: mode = MODE_STEP;
         default:        mode = MODE_OFF;
      endcase
   end

   // Setpoint is used only while enabled; torque also needs closed loop.
   assign follow = OP_ENABLED_I & ((mode == MODE_CSV) | ((mode == MODE_CST) & CLOSED_LOOP_I));

   // Object writes; read-only and unknown indices are refused.
   always_comb begin
      unique case (OBJ_INDEX_I)
         IDX_STEP_NUM, IDX_STEP_DEN, IDX_CONTROL, IDX_MODE_SELECT, IDX_TQ_SETPOINT, IDX_TQ_CEILING,
         IDX_CUR_CEILING, IDX_SPD_CEILING, IDX_VEL_OFFSET, IDX_TQ_OFFSET, IDX_VEL_SETPOINT: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // Control word is stored only; it steers nothing in these modes.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         num_q     <= RST_STEP_NUM;
         den_q     <= RST_STEP_DEN;
         ctrl_q    <= RST_ZERO16;
         mode_q    <= RST_MODE;
         tq_set_q  <= RST_ZERO16;
         tq_max_q  <= RST_ZERO16;
         cur_max_q <= RST_ZERO16;
         spd_max_q <= RST_ZERO32;
         vel_off_q <= RST_ZERO32;
         tq_off_q  <= RST_ZERO16;
         vel_set_q <= RST_ZERO32;
      end else if (OBJ_WR_I && wr_ok) begin
         unique case (OBJ_INDEX_I)
            IDX_STEP_NUM:     num_q     <= OBJ_WDATA_I;
            IDX_STEP_DEN:     den_q     <= OBJ_WDATA_I;
            IDX_CONTROL:      ctrl_q    <= OBJ_WDATA_I[15:0];
            IDX_MODE_SELECT:  mode_q    <= OBJ_WDATA_I[7:0];
            IDX_TQ_SETPOINT:  tq_set_q  <= OBJ_WDATA_I[15:0];
            IDX_TQ_CEILING:   tq_max_q  <= OBJ_WDATA_I[15:0];
            IDX_CUR_CEILING:  cur_max_q <= OBJ_WDATA_I[15:0];
            IDX_SPD_CEILING:  spd_max_q <= OBJ_WDATA_I;
            IDX_VEL_OFFSET:   vel_off_q <= OBJ_WDATA_I;
            IDX_TQ_OFFSET:    tq_off_q  <= OBJ_WDATA_I[15:0];
            IDX_VEL_SETPOINT: vel_set_q <= OBJ_WDATA_I;
            default:          ;
         endcase
      end
   end

   // Read multiplexer; narrow objects sit in the low bits.
   always_comb begin
      rd_hit = 1'b1;
      unique case (OBJ_INDEX_I)
         IDX_STEP_NUM:     rd_mux = num_q;
         IDX_STEP_DEN:     rd_mux = den_q;
         IDX_CONTROL:      rd_mux = {16'h0000, ctrl_q};
         IDX_STATUS:       rd_mux = {16'h0000, status};
         IDX_MODE_SELECT:  rd_mux = {24'h000000, mode_q};
         IDX_TQ_SETPOINT:  rd_mux = {16'h0000, tq_set_q};
         IDX_TQ_CEILING:   rd_mux = {16'h0000, tq_max_q};
         IDX_CUR_CEILING:  rd_mux = {16'h0000, cur_max_q};
         IDX_TQ_READBACK:  rd_mux = {16'h0000, TORQUE_DEMAND_O};
         IDX_SPD_CEILING:  rd_mux = spd_max_q;
         IDX_VEL_OFFSET:   rd_mux = vel_off_q;
         IDX_TQ_OFFSET:    rd_mux = {16'h0000, tq_off_q};
         IDX_VEL_SETPOINT: rd_mux = vel_set_q;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Access answer one cycle after the strobe.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         OBJ_RDATA_O <= RST_ZERO32;
         OBJ_ACK_O   <= 1'b0;
         OBJ_ERR_O   <= 1'b0;
      end else begin
         OBJ_ACK_O <= OBJ_WR_I | OBJ_RD_I;
         OBJ_ERR_O <= (OBJ_WR_I & ~wr_ok) | (OBJ_RD_I & ~rd_hit);
         if (OBJ_RD_I) begin
            OBJ_RDATA_O <= rd_mux;
         end
      end
   end

   // Millisecond base from the core clock.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ms_cnt_q <= RST_ZERO32;
      end else if (ms_tick) begin
         ms_cnt_q <= RST_ZERO32;
      end else begin
         ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
      end
   end
   assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES_P - 1));

   // Cycle time is the period count of milliseconds; other indices halt it.
   assign index_ok    = (TIME_INDEX_I == TIME_INDEX_MS);
   assign period_last = (CYCLE_PERIOD_I == 8'h00) ? 8'h00 : CYCLE_PERIOD_I - 8'h01;
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         cyc_cnt_q <= 8'h00;
      end else if (ms_tick) begin
         cyc_cnt_q <= (cyc_cnt_q >= period_last) ? 8'h00 : cyc_cnt_q + 8'h01;
      end
   end
   assign cycle_tick = ms_tick & (cyc_cnt_q >= period_last) & index_ok;

   // Sync status: a sync event seen during the last cycle; a new event wins over the clear.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         sync_seen_q <= 1'b0;
         in_sync_q   <= 1'b0;
      end else if (cycle_tick) begin
         in_sync_q   <= sync_seen_q | SYNC_I;
         sync_seen_q <= SYNC_I;
      end else if (SYNC_I) begin
         sync_seen_q <= 1'b1;
      end
   end

   // Offsets added, then clamped to the limits.
   assign vel_sum = {vel_set_q[31], vel_set_q} + {vel_off_q[31], vel_off_q};
   assign vel_lim = {1'b0, spd_max_q};
   assign tq_sum  = {tq_set_q[15], tq_set_q} + {tq_off_q[15], tq_off_q};
   assign tq_lim  = {1'b0, (tq_max_q < cur_max_q) ? tq_max_q : cur_max_q};

   // Demands refresh once per cycle while the setpoint is followed.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         VEL_DEMAND_O    <= RST_ZERO32;
         TORQUE_DEMAND_O <= RST_ZERO16;
      end else if (cycle_tick) begin
         VEL_DEMAND_O    <= RST_ZERO32;
         TORQUE_DEMAND_O <= RST_ZERO16;
         if (follow && mode == MODE_CSV) begin
            if ($signed(vel_sum) > $signed(vel_lim)) begin
               VEL_DEMAND_O <= spd_max_q;
            end else if ($signed(vel_sum) < -$signed(vel_lim)) begin
               VEL_DEMAND_O <= 32'(-vel_lim);
            end else begin
               VEL_DEMAND_O <= vel_sum[31:0];
            end
         end
         if (follow && mode == MODE_CST) begin
            if ($signed(tq_sum) > $signed(tq_lim)) begin
               TORQUE_DEMAND_O <= tq_lim[15:0];
            end else if ($signed(tq_sum) < -$signed(tq_lim)) begin
               TORQUE_DEMAND_O <= 16'(-tq_lim);
            end else begin
               TORQUE_DEMAND_O <= tq_sum[15:0];
            end
         end
      end
   end

   // Pulse counting runs on the link clock.
   cssd_step_capture u_capture (
      .clk_i        (LINK_CLK_I),
      .rst_n_i      (RST_N_I),
      .step_i       (STEP_CLK_I),
      .dir_i        (STEP_DIR_I),
      .subtype_i    (STEP_SUBTYPE_I),
      .total_gray_o (gray_sync_src)
   );

   // Gray total crosses into the core domain.
   cssd_sync2 #(.W(CNT_W)) u_gray_sync (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .d_i     (gray_sync_src),
      .q_o     (gray_sync)
   );

   // Gray to binary.
   always_comb begin
      total_bin[CNT_W-1] = gray_sync[CNT_W-1];
      for (int i = CNT_W - 2; i >= 0; i--) begin
         total_bin[i] = total_bin[i+1] ^ gray_sync[i];
      end
   end

   // Pulses collected in this cycle as a signed difference.
   assign delta     = total_bin - snap_q;
   assign delta_mag = delta[CNT_W-1] ? 16'(-delta) : delta;
   assign rem_sh    = {rem_q[31:0], dvd_q[DVD_W-1]};

   // Once per cycle: scale the pulse count by the ratio and move the demand position.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         snap_q       <= RST_ZERO16;
         div_st_q     <= DIV_IDLE;
         div_cnt_q    <= 6'h00;
         dvd_q        <= '0;
         rem_q        <= '0;
         neg_q        <= 1'b0;
         POS_DEMAND_O <= RST_ZERO32;
      end else begin
         unique case (div_st_q)
            DIV_IDLE: begin
               if (cycle_tick) begin
                  snap_q <= total_bin;
                  if (mode == MODE_STEP && den_q != RST_ZERO32) begin
                     dvd_q     <= 48'(delta_mag) * 48'(num_q);
                     neg_q     <= delta[CNT_W-1];
                     rem_q     <= '0;
                     div_cnt_q <= DIV_STEPS;
                     div_st_q  <= DIV_RUN;
                  end
               end
            end
            DIV_RUN: begin
               if (rem_sh >= {1'b0, den_q}) begin
                  rem_q <= rem_sh - {1'b0, den_q};
                  dvd_q <= {dvd_q[DVD_W-2:0], 1'b1};
               end else begin
                  rem_q <= rem_sh;
                  dvd_q <= {dvd_q[DVD_W-2:0], 1'b0};
               end
               div_cnt_q <= div_cnt_q - 6'h01;
               if (div_cnt_q == 6'h01) begin
                  div_st_q <= DIV_IDLE;
               end
            end
         endcase
         if (div_st_q == DIV_RUN && div_cnt_q == 6'h01) begin
            POS_DEMAND_O <= neg_q ? POS_DEMAND_O - {dvd_q[30:0], (rem_sh >= {1'b0, den_q})}
                                  : POS_DEMAND_O + {dvd_q[30:0], (rem_sh >= {1'b0, den_q})};
         end
      end
   end

   // Following error: outside the window for longer than the timeout in milliseconds.
   assign pos_err     = POS_DEMAND_O - ACTUAL_POS_I;
   assign pos_err_mag = pos_err[31] ? 32'(-pos_err) : pos_err;
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         fe_ms_q <= RST_ZERO16;
         ferr_q  <= 1'b0;
      end else if (mode != MODE_STEP || !CLOSED_LOOP_I || pos_err_mag <= FE_WINDOW_I) begin
         fe_ms_q <= RST_ZERO16;
         ferr_q  <= 1'b0;
      end else if (ms_tick) begin
         if (fe_ms_q != 16'hFFFF) begin
            fe_ms_q <= fe_ms_q + 16'h0001;
         end
         ferr_q <= (fe_ms_q >= FE_TIMEOUT_I);
      end
   end

   // Status word assembly.
   always_comb begin
      status = RST_ZERO16;
      if (mode == MODE_CSV || mode == MODE_CST) begin
         status[SW_SYNC_BIT]   = in_sync_q;
         status[SW_FOLLOW_BIT] = follow;
      end
      if (mode == MODE_STEP) begin
         status[SW_FERR_BIT] = ferr_q;
      end
   end

   assign STATUS_WORD_O    = status;
   assign CYCLE_TICK_O     = cycle_tick;
   assign TIME_INDEX_ERR_O = ~index_ok;
   assign STEPS_PER_REV_O  = 16'(POLE_PAIRS_I) * 16'(FULL_STEPS_PER_POLE_PAIR);

endmodule : cssd_top

// File: bench/cssd_top_asserts.sv
// Checker bound to the front end top: object port, cycle timer and demand timing.
module cssd_top_asserts
   import cssd_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = 50
) (
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        OBJ_WR_I,
   input wire logic        OBJ_RD_I,
   input wire logic [15:0] OBJ_INDEX_I,
   input wire logic        OBJ_ACK_O,
   input wire logic        OBJ_ERR_O,
   input wire logic [7:0]  CYCLE_PERIOD_I,
   input wire logic [7:0]  TIME_INDEX_I,
   input wire logic        TIME_INDEX_ERR_O,
   input wire logic        CYCLE_TICK_O,
   input wire logic [7:0]  POLE_PAIRS_I,
   input wire logic [15:0] STEPS_PER_REV_O,
   input wire logic [31:0] POS_DEMAND_O,
   input wire logic [15:0] STATUS_WORD_O
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned gap_q;
   logic        seen_q;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Counts core cycles since the last tick; the first tick after reset has a free phase.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I || CYCLE_TICK_O)
         gap_q <= 0;
      else
         gap_q <= gap_q + 1;
   end
   // Remembers that one tick was seen, so only full gaps are judged.
   always_ff @(posedge CLK_I) begin
      seen_q <= RST_N_I && (seen_q || CYCLE_TICK_O);
   end
   ack_after_strobe_a: assert property ((OBJ_WR_I || OBJ_RD_I) |=> OBJ_ACK_O) else $error("no ack");
   ack_has_cause_a: assert property (OBJ_ACK_O |-> $past(OBJ_WR_I || OBJ_RD_I)) else $error("stray ack");
   err_with_ack_a: assert property (OBJ_ERR_O |-> OBJ_ACK_O) else $error("error without ack");
   ro_write_err_a: assert property (OBJ_WR_I && OBJ_INDEX_I == IDX_STATUS |=> OBJ_ERR_O)
      else $error("status write taken");
   index_flag_a: assert property (TIME_INDEX_ERR_O == (TIME_INDEX_I != TIME_INDEX_MS))
      else $error("time index flag wrong");
   no_tick_bad_a: assert property (TIME_INDEX_ERR_O |-> !CYCLE_TICK_O) else $error("tick on bad index");
   tick_gap_a: assert property (CYCLE_TICK_O && seen_q |->
      gap_q == MS_CYCLES_P * (CYCLE_PERIOD_I == 8'h00 ? 1 : CYCLE_PERIOD_I) - 1) else $error("tick gap wrong");
   pos_update_a: assert property ($changed(POS_DEMAND_O) |-> $past(CYCLE_TICK_O, 49))
      else $error("position changed off cycle");
   steps_rev_a: assert property (STEPS_PER_REV_O == {6'h00, POLE_PAIRS_I, 2'b00})
      else $error("steps per revolution wrong");
   tick_c: cover property (CYCLE_TICK_O);
   err_c: cover property (OBJ_ERR_O);
   pos_c: cover property ($changed(POS_DEMAND_O));
   ferr_c: cover property (STATUS_WORD_O[SW_FERR_BIT]);
endmodule : cssd_top_asserts

bind cssd_top cssd_top_asserts #(.MS_CYCLES_P(MS_CYCLES_P)) i_chk (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .OBJ_WR_I(OBJ_WR_I), .OBJ_RD_I(OBJ_RD_I), .OBJ_INDEX_I(OBJ_INDEX_I),
   .OBJ_ACK_O(OBJ_ACK_O), .OBJ_ERR_O(OBJ_ERR_O), .CYCLE_PERIOD_I(CYCLE_PERIOD_I), .TIME_INDEX_I(TIME_INDEX_I),
   .TIME_INDEX_ERR_O(TIME_INDEX_ERR_O), .CYCLE_TICK_O(CYCLE_TICK_O), .POLE_PAIRS_I(POLE_PAIRS_I),
   .STEPS_PER_REV_O(STEPS_PER_REV_O), .POS_DEMAND_O(POS_DEMAND_O), .STATUS_WORD_O(STATUS_WORD_O));

// File: bench/cssd_step_host.sv
// Model of the positioning controller that drives the step and direction pins.
module cssd_step_host (
   input  wire logic link_clk_i,
   output logic      step_o,
   output logic      dir_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins idle with no pulse and forward sense.
   initial begin
      step_o = 1'b0;
      dir_o  = 1'b1;
   end
   // Sends n pulses; a new sense is settled before the first pulse.
   task automatic send(input int n, input logic fwd);
      if (fwd !== dir_o) begin
         dir_o = fwd;
         #35000;
      end
      repeat (n) begin
         @(posedge link_clk_i);
         step_o <= 1'b1;
         repeat (7) @(posedge link_clk_i);
         step_o <= 1'b0;
         repeat (7) @(posedge link_clk_i);
      end
   endtask : send
endmodule : cssd_step_host

// File: bench/cssd_top_bench.sv
// Self-checking bench for the cyclic setpoint and step/direction front end.
module cssd_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import cssd_pkg::*;
   logic        clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, sync = 1'b0, open = 1'b1, closed = 1'b0, sub = 1'b0;
   logic        wr = 1'b0, rd = 1'b0, ack, err, tick, tierr, step, dir;
   logic [7:0]  tidx = 8'hFD;
   logic [15:0] idx = 16'h0000, tq, sw, spr;
   logic [31:0] wd = 32'h0, apos = 32'h0, rdata, vel, pos, rv;
   int          error_cnt = 0, checked = 0, cyc = 0, n;
   always #2 clk = ~clk;
   // The link clock starts off phase with the core clock.
   initial begin
      #7;
      forever #16 lclk = ~lclk;
   end
   cssd_step_host i_host (.link_clk_i(lclk), .step_o(step), .dir_o(dir));
   cssd_top #(.MS_CYCLES_P(50)) i_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .LINK_CLK_I(lclk), .STEP_CLK_I(step), .STEP_DIR_I(dir), .STEP_SUBTYPE_I(sub),
      .SYNC_I(sync), .OP_ENABLED_I(open), .CLOSED_LOOP_I(closed), .CYCLE_PERIOD_I(8'h01), .TIME_INDEX_I(tidx),
      .ACTUAL_POS_I(apos), .FE_WINDOW_I(32'h64), .FE_TIMEOUT_I(16'h0001), .POLE_PAIRS_I(8'h03), .OBJ_WR_I(wr),
      .OBJ_RD_I(rd), .OBJ_INDEX_I(idx), .OBJ_WDATA_I(wd), .OBJ_RDATA_O(rdata), .OBJ_ACK_O(ack), .OBJ_ERR_O(err),
      .VEL_DEMAND_O(vel), .TORQUE_DEMAND_O(tq), .POS_DEMAND_O(pos), .STATUS_WORD_O(sw), .CYCLE_TICK_O(tick),
      .TIME_INDEX_ERR_O(tierr), .STEPS_PER_REV_O(spr));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One object access; the answer is taken the cycle after the strobe.
   task automatic obj(input logic w, input logic [15:0] i, input logic [31:0] d, input logic ee);
      @(negedge clk);
      {wr, rd, idx, wd} = {w, !w, i, d};
      @(negedge clk);
      {wr, rd} = 2'b00;
      rv = rdata;
      chk("ack", 32'h1, {31'h0, ack});
      chk("err", {31'h0, ee}, {31'h0, err});
   endtask : obj
   // Waits for k interpolation ticks, then for the demand registers to load.
   task automatic tk(input int k);
      repeat (k) begin
         do @(negedge clk); while (tick !== 1'b1);
      end
      @(negedge clk);
   endtask : tk
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic t_regs;
      obj(0, IDX_STEP_NUM, 32'h0, 0);
      chk("num", RST_STEP_NUM, rv);
      obj(0, IDX_STEP_DEN, 32'h0, 0);
      chk("den", RST_STEP_DEN, rv);
      obj(0, 16'h1234, 32'h0, 1);
      chk("unmapped", 32'h0, rv);
      obj(1, IDX_STATUS, 32'hFFFF, 1);
   endtask : t_regs
   task automatic t_vel;
      obj(1, IDX_MODE_SELECT, 32'h9, 0);
      obj(1, IDX_SPD_CEILING, 32'h3E8, 0);
      obj(1, IDX_VEL_OFFSET, 32'h5, 0);
      obj(1, IDX_VEL_SETPOINT, 32'h64, 0);
      tk(1);
      sync = 1'b1;
      @(negedge clk);
      sync = 1'b0;
      tk(1);
      chk("vel", 32'h69, vel);
      chk("sync", 32'h1, {31'h0, sw[SW_SYNC_BIT]});
      chk("follow", 32'h1, {31'h0, sw[SW_FOLLOW_BIT]});
      obj(1, IDX_CONTROL, 32'hFFFF, 0);
      obj(1, IDX_VEL_SETPOINT, 32'h7D0, 0);
      tk(1);
      chk("vel clamp", 32'h3E8, vel);
      chk("no sync", 32'h0, {31'h0, sw[SW_SYNC_BIT]});
   endtask : t_vel
   task automatic t_tq;
      closed = 1'b1;
      obj(1, IDX_MODE_SELECT, 32'hA, 0);
      obj(1, IDX_TQ_CEILING, 32'h1F4, 0);
      obj(1, IDX_CUR_CEILING, 32'h12C, 0);
      obj(1, IDX_TQ_OFFSET, 32'hA, 0);
      obj(1, IDX_TQ_SETPOINT, 32'h64, 0);
      tk(1);
      chk("torque", 32'h6E, {16'h0, tq});
      obj(1, IDX_TQ_SETPOINT, 32'h190, 0);
      tk(1);
      chk("torque clamp", 32'h12C, {16'h0, tq});
      closed = 1'b0;
      tk(2);
      chk("open loop", 32'h0, {16'h0, tq});
      chk("open follow", 32'h0, {31'h0, sw[SW_FOLLOW_BIT]});
   endtask : t_tq
   task automatic t_step;
      closed = 1'b1;
      obj(1, IDX_MODE_SELECT, 32'hFF, 0);
      i_host.send(10, 1'b1);
      tk(2);
      repeat (50) @(negedge clk);
      chk("pos fwd", 32'h500, pos);
      chk("ferr", 32'h1, {31'h0, sw[SW_FERR_BIT]});
      apos = 32'h500;
      repeat (3) @(negedge clk);
      chk("ferr clear", 32'h0, {31'h0, sw[SW_FERR_BIT]});
      i_host.send(4, 1'b0);
      tk(2);
      repeat (50) @(negedge clk);
      chk("pos rev", 32'h300, pos);
      // Subtype 1: the direction pin's rise is one reverse pulse, then three forward pulses.
      sub = 1'b1;
      i_host.send(3, 1'b1);
      tk(2);
      repeat (50) @(negedge clk);
      chk("pos cw ccw", 32'h400, pos);
   endtask : t_step
   task automatic t_idx;
      chk("steps rev", 32'hC, {16'h0, spr});
      tidx = 8'h00;
      n = 0;
      repeat (120) begin
         @(negedge clk);
         n += (tick === 1'b1);
      end
      chk("index err", 32'h1, {31'h0, tierr});
      chk("ticks", 32'h0, n);
   endtask : t_idx
   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         test_done;
      end
   end
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      t_regs;
      t_vel;
      t_tq;
      t_step;
      t_idx;
      test_done;
   end
endmodule : cssd_top_bench
